//--- common/aei_pkg.sv
// Package with register map, field positions and timing for the accessory event interrupts
package aei_pkg;
   localparam logic [5:0] ADDR_ENABLE_WRITE = 6'h1D;
   localparam logic [5:0] ADDR_ENABLE_SET = 6'h1E;
   localparam logic [5:0] ADDR_ENABLE_CLEAR = 6'h1F;
   localparam logic [5:0] ADDR_STATUS = 6'h20;
   localparam logic [5:0] ADDR_LATCH = 6'h21;
   localparam logic [5:0] ADDR_VENDOR_LO = 6'h30;
   localparam logic [5:0] ADDR_VENDOR_HI = 6'h3F;
   localparam logic [5:0] ADDR_CONV_READ_LO = 6'h36;
   localparam logic [5:0] ADDR_CONV_READ_HI = 6'h38;
   localparam int EN_ID_RISE = 0;
   localparam int EN_ID_FALL = 1;
   localparam int EN_VDET = 2;
   localparam int EN_RDONE = 5;
   localparam logic [7:0] ENABLE_WRITE_MASK = 8'h27;
   localparam int ST_ID_OPEN = 0;
   localparam int ST_VDET = 1;
   localparam int ST_CODE_LO = 3;
   localparam int ST_DONE = 6;
   localparam int LT_ID = 0;
   localparam int LT_VDET = 1;
   localparam int LT_DONE = 3;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [2:0] CODE_ID_OPEN = 3'h5;
   localparam logic [2:0] CODE_ERROR = 3'h7;
   localparam int CONV_TIME_NS = 282000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } aei_req_s;
   typedef struct packed {
      logic id_open;
      logic vdet;
      logic [2:0] code;
   } aei_sense_s;
endpackage

//--- logic/aei_sync.sv
// Three-stage input synchroniser with second/third agreement
`timescale 1ns/1ps
module aei_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk, // Clock
   input wire logic srst, // Sync reset
   input wire logic [W-1:0] d, // Async input
   output logic [W-1:0] q // Filtered output
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         q <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               q[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule

//--- logic/aei_core.sv
// Accessory event enable, status and latch registers with alt_int output
`timescale 1ns/1ps
module aei_core #(
   parameter int CONV_CYCLES = aei_pkg::CONV_CYCLES
) (
   input wire logic sys_clk, // 25 MHz clock
   input wire logic srst, // Sync reset, high
   input wire aei_pkg::aei_req_s req, // Register access strobe
   output logic [7:0] rdata, // Read data, registered
   output logic rdata_valid, // Read data valid pulse
   output logic vendor_hit, // Access falls in vendor range
   input wire logic id_open_raw, // ID pin floating, async
   input wire logic line_voltage_raw, // Voltage comparator, async
   input wire logic [2:0] code_in, // Converter result code
   input wire logic conv_start, // Conversion start pulse
   input wire logic vendor_done_enable, // Vendor conversion irq enable
   output logic alt_int // Interrupt flag for RX CMD
);
   typedef enum logic [1:0] {
      CV_IDLE = 2'b01,
      CV_RUN = 2'b10
   } aei_conv_e;
   localparam int CW = $clog2(CONV_CYCLES + 1);
   localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

   aei_pkg::aei_sense_s sense;
   aei_pkg::aei_sense_s sense_prev_reg;
   logic [7:0] enable_reg;
   logic [7:0] latch_reg;
   logic [7:0] latch_next;
   logic done_reg;
   logic done_prev_reg;
   logic [2:0] code_reg;
   logic [CW-1:0] cnt_reg;
   aei_conv_e cv_reg;
   logic [7:0] status_byte;
   logic rdone_en;
   logic ev_id;
   logic ev_vdet;
   logic ev_done;
   logic conv_end;

   aei_sync #(.W(2)) u_sync (
      .sys_clk(sys_clk),
      .srst(srst),
      .d({line_voltage_raw, id_open_raw}),
      .q({sense.vdet, sense.id_open})
   );
   assign sense.code = code_reg;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sense_prev_reg <= '0;
         done_prev_reg <= 1'b0;
      end else begin
         sense_prev_reg <= sense;
         done_prev_reg <= done_reg;
      end
   end

   // Enable byte with write, set and clear aliases
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         enable_reg <= aei_pkg::RESET_BYTE;
      end else if (req.wr) begin
         unique case (req.addr)
            aei_pkg::ADDR_ENABLE_WRITE: enable_reg <= req.wdata
               & aei_pkg::ENABLE_WRITE_MASK;
            aei_pkg::ADDR_ENABLE_SET: enable_reg <= (enable_reg | req.wdata)
               & aei_pkg::ENABLE_WRITE_MASK;
            aei_pkg::ADDR_ENABLE_CLEAR: enable_reg <= enable_reg & ~req.wdata;
            default: enable_reg <= enable_reg;
         endcase
      end
   end

   assign rdone_en = enable_reg[aei_pkg::EN_RDONE] | vendor_done_enable;
   assign conv_end = (cv_reg == CV_RUN) && (cnt_reg == CONV_LAST);

   // Conversion timer
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cv_reg <= CV_IDLE;
         cnt_reg <= '0;
         code_reg <= 3'h0;
      end else begin
         unique case (cv_reg)
            CV_IDLE: begin
               cnt_reg <= '0;
               if (conv_start) begin
                  cv_reg <= CV_RUN;
               end
            end
            CV_RUN: begin
               cnt_reg <= cnt_reg + CW'(1);
               if (conv_end) begin
                  cv_reg <= CV_IDLE;
                  code_reg <= code_in;
               end
            end
            default: cv_reg <= CV_IDLE;
         endcase
      end
   end

   logic conv_code_read;
   assign conv_code_read = req.rd && req.addr >= aei_pkg::ADDR_CONV_READ_LO
      && req.addr <= aei_pkg::ADDR_CONV_READ_HI;

   // Done flag: set wins over clear
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         done_reg <= 1'b0;
      end else if (conv_end) begin
         done_reg <= 1'b1;
      end else if (conv_code_read) begin
         done_reg <= 1'b0;
      end
   end

   assign ev_id = (enable_reg[aei_pkg::EN_ID_RISE] && sense.id_open && !sense_prev_reg.id_open)
      || (enable_reg[aei_pkg::EN_ID_FALL] && !sense.id_open
      && sense_prev_reg.id_open);
   assign ev_vdet = enable_reg[aei_pkg::EN_VDET] && (sense.vdet != sense_prev_reg.vdet);
   assign ev_done = rdone_en && done_reg && !done_prev_reg;

   always_comb begin
      latch_next = latch_reg;
      if (req.rd && req.addr == aei_pkg::ADDR_LATCH) begin
         latch_next = 8'h00;
      end
      if (ev_id) latch_next[aei_pkg::LT_ID] = 1'b1;
      if (ev_vdet) latch_next[aei_pkg::LT_VDET] = 1'b1;
      if (ev_done) latch_next[aei_pkg::LT_DONE] = 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         latch_reg <= aei_pkg::RESET_BYTE;
      end else begin
         latch_reg <= latch_next;
      end
   end

   always_comb begin
      status_byte = 8'h00;
      status_byte[aei_pkg::ST_ID_OPEN] = sense.id_open;
      status_byte[aei_pkg::ST_VDET] = sense.vdet;
      status_byte[aei_pkg::ST_CODE_LO +: 3] = sense.code;
      status_byte[aei_pkg::ST_DONE] = done_reg;
   end

   // Read mux
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata <= 8'h00;
         rdata_valid <= 1'b0;
      end else begin
         rdata_valid <= req.rd;
         if (req.rd) begin
            unique case (req.addr)
               aei_pkg::ADDR_ENABLE_WRITE, aei_pkg::ADDR_ENABLE_SET,
               aei_pkg::ADDR_ENABLE_CLEAR: rdata <= enable_reg;
               aei_pkg::ADDR_STATUS: rdata <= status_byte;
               aei_pkg::ADDR_LATCH: rdata <= latch_reg;
               default: rdata <= 8'h00;
            endcase
         end
      end
   end

   assign vendor_hit = (req.rd || req.wr) && req.addr >= aei_pkg::ADDR_VENDOR_LO
      && req.addr <= aei_pkg::ADDR_VENDOR_HI;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         alt_int <= 1'b0;
      end else begin
         alt_int <= ev_id || ev_vdet || ev_done;
      end
   end

   // Checker helpers
   localparam logic [CW-1:0] CONV_TOTAL = CW'(CONV_CYCLES);
   logic [CW-1:0] run_len_reg;
   logic en_access;
   logic map_hit;
   assign en_access = req.wr && req.addr >= aei_pkg::ADDR_ENABLE_WRITE
      && req.addr <= aei_pkg::ADDR_ENABLE_CLEAR;
   assign map_hit = req.addr >= aei_pkg::ADDR_ENABLE_WRITE
      && req.addr <= aei_pkg::ADDR_LATCH;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         run_len_reg <= '0;
      end else if (cv_reg == CV_RUN) begin
         run_len_reg <= run_len_reg + CW'(1);
      end else begin
         run_len_reg <= '0;
      end
   end

   // Enable register
   AST_EN_WRITE: assert property (@(posedge sys_clk) disable iff (srst)
      req.wr && req.addr == aei_pkg::ADDR_ENABLE_WRITE
      |=> enable_reg == ($past(req.wdata) & aei_pkg::ENABLE_WRITE_MASK))
      else $error("plain enable write wrong");

   AST_EN_SET: assert property (@(posedge sys_clk) disable iff (srst)
      req.wr && req.addr == aei_pkg::ADDR_ENABLE_SET |=> (enable_reg & ($past(req.wdata)
      & aei_pkg::ENABLE_WRITE_MASK)) == ($past(req.wdata) & aei_pkg::ENABLE_WRITE_MASK))
      else $error("set alias lost bits");

   AST_EN_CLR: assert property (@(posedge sys_clk) disable iff (srst)
      req.wr && req.addr == aei_pkg::ADDR_ENABLE_CLEAR |=> (enable_reg & $past(req.wdata)) == 8'h00)
      else $error("clear alias left bits");

   AST_EN_KEEP: assert property (@(posedge sys_clk) disable iff (srst)
      !en_access |=> $stable(enable_reg))
      else $error("enable changed without write");

   AST_EN_RSV: assert property (@(posedge sys_clk) disable iff (srst)
      (enable_reg & ~aei_pkg::ENABLE_WRITE_MASK) == 8'h00)
      else $error("reserved enable bit set");

   // Event capture
   AST_ID_EDGE: assert property (@(posedge sys_clk) disable iff (srst)
      ev_id |=> alt_int && latch_reg[aei_pkg::LT_ID])
      else $error("id edge not latched");

   AST_VDET: assert property (@(posedge sys_clk) disable iff (srst)
      enable_reg[aei_pkg::EN_VDET] && $changed(sense.vdet) |=> latch_reg[aei_pkg::LT_VDET])
      else $error("voltage change not latched");

   AST_DONE_LATCH: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(done_reg) && rdone_en |=> latch_reg[aei_pkg::LT_DONE] ##0 alt_int)
      else $error("done not latched");

   AST_LATCH_CLR: assert property (@(posedge sys_clk) disable iff (srst)
      req.rd && req.addr == aei_pkg::ADDR_LATCH && !ev_id && !ev_vdet && !ev_done
      |=> latch_reg == 8'h00)
      else $error("latch not cleared by read");

   AST_LATCH_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
      latch_reg[aei_pkg::LT_ID] && !(req.rd && req.addr == aei_pkg::ADDR_LATCH)
      |=> latch_reg[aei_pkg::LT_ID])
      else $error("latch lost without read");

   AST_LATCH_RSV: assert property (@(posedge sys_clk) disable iff (srst)
      latch_reg[7:4] == 4'h0 && latch_reg[2] == 1'b0)
      else $error("reserved latch bit set");

   AST_NO_INT: assert property (@(posedge sys_clk) disable iff (srst)
      enable_reg == 8'h00 && !vendor_done_enable |=> !alt_int)
      else $error("alt_int without enable");

   // Conversion
   AST_DONE_TIME: assert property (@(posedge sys_clk) disable iff (srst)
      cv_reg == CV_IDLE && conv_start |=> cv_reg == CV_RUN && cnt_reg == '0 && !conv_end)
      else $error("conversion finished early");

   AST_DONE_SET: assert property (@(posedge sys_clk) disable iff (srst)
      conv_end |=> done_reg)
      else $error("done not set at conversion end");

   AST_DONE_PERIOD: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(done_reg) |-> run_len_reg == CONV_TOTAL)
      else $error("conversion length wrong");

   AST_CONV_KEEP: assert property (@(posedge sys_clk) disable iff (srst)
      cv_reg == CV_RUN && !conv_end |=> cv_reg == CV_RUN)
      else $error("conversion cut short");

   AST_DONE_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
      done_reg && !conv_code_read |=> done_reg)
      else $error("done cleared without vendor read");

   AST_CODE: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(done_reg) |-> sense.code == $past(code_in))
      else $error("resistance code not captured");

   AST_CV_ONEHOT: assert property (@(posedge sys_clk) disable iff (srst)
      $onehot(cv_reg))
      else $error("conversion state not one-hot");

   // Read path
   AST_STATUS_RD: assert property (@(posedge sys_clk) disable iff (srst)
      req.rd && req.addr == aei_pkg::ADDR_STATUS |=> rdata == $past(status_byte)
      && rdata[7] == 1'b0 && rdata[2] == 1'b0)
      else $error("status read wrong");

   AST_EN_RD: assert property (@(posedge sys_clk) disable iff (srst)
      req.rd && req.addr >= aei_pkg::ADDR_ENABLE_WRITE && req.addr <= aei_pkg::ADDR_ENABLE_CLEAR
      |=> rdata == $past(enable_reg))
      else $error("enable read wrong");

   AST_LATCH_RD: assert property (@(posedge sys_clk) disable iff (srst)
      req.rd && req.addr == aei_pkg::ADDR_LATCH |=> rdata == $past(latch_reg))
      else $error("latch read wrong");

   AST_UNMAPPED: assert property (@(posedge sys_clk) disable iff (srst)
      req.rd && !map_hit |=> rdata == 8'h00)
      else $error("unmapped read not zero");

   AST_RDV: assert property (@(posedge sys_clk) disable iff (srst)
      req.rd |=> rdata_valid)
      else $error("read valid missing");

   AST_RDV_IDLE: assert property (@(posedge sys_clk) disable iff (srst)
      !req.rd |=> !rdata_valid)
      else $error("read valid without read");

   AST_VENDOR: assert property (@(posedge sys_clk) disable iff (srst)
      vendor_hit |-> (req.rd || req.wr) && req.addr[5:4] == 2'h3)
      else $error("vendor decode wrong");

   // Scenario coverage
   COV_ID: cover property (@(posedge sys_clk) disable iff (srst)
      ev_id ##1 alt_int);
   COV_VDET: cover property (@(posedge sys_clk) disable iff (srst)
      ev_vdet ##1 alt_int);
   COV_CONV: cover property (@(posedge sys_clk) disable iff (srst)
      conv_end ##2 latch_reg[aei_pkg::LT_DONE]);
   COV_DONE_CLR: cover property (@(posedge sys_clk) disable iff (srst)
      done_reg && conv_code_read ##1 !done_reg);
   COV_LATCH_RD: cover property (@(posedge sys_clk) disable iff (srst)
      latch_reg != 8'h00 && req.rd && req.addr == aei_pkg::ADDR_LATCH);
endmodule

//--- tb/aei_link_model.sv
// Link-side model that turns bench commands into one-cycle register strobes
`timescale 1ns/1ps
module aei_link_model (
   input wire logic sys_clk, // Clock
   input wire logic go, // Issue one access
   input wire logic wr_sel, // 1 write, 0 read
   input wire logic [5:0] addr, // Register address
   input wire logic [7:0] wdata, // Write byte
   output aei_pkg::aei_req_s req, // Strobe to block
   input wire logic [7:0] rdata, // Read data from block
   input wire logic rdata_valid, // Read data valid
   output logic [7:0] rd_byte, // Captured read byte
   output logic id_pin_pullup_enable // Pull-up held on
);
   // Pull-up on so that the float status can be trusted
   assign id_pin_pullup_enable = 1'b1;
   // Idle bus shows inverted values, never a stale copy
   always_comb begin
      req.addr = go ? addr : ~addr;
      req.wdata = go ? wdata : ~wdata;
      req.wr = go & wr_sel;
      req.rd = go & ~wr_sel;
   end
   always_ff @(posedge sys_clk) begin
      if (rdata_valid) rd_byte <= rdata;
   end
endmodule

//--- tb/aei_core_tb.sv
// Self-checking bench for the accessory event interrupt registers
`timescale 1ns/1ps
module aei_core_tb;
   localparam int CONV = 20;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic go = 1'b0;
   logic wr_sel = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [7:0] wdata = 8'h00;
   logic id_open_raw = 1'b0;
   logic line_voltage_raw = 1'b0;
   logic [2:0] code_in = 3'h0;
   logic conv_start = 1'b0;
   logic vendor_done_enable = 1'b0;
   aei_pkg::aei_req_s req;
   logic [7:0] rdata, rd_byte, b;
   logic rdata_valid, vendor_hit, alt_int, hit, pull_on;
   int fail_count = 0;
   int n_tests = 0;
   int irq_n = 0;
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (alt_int === 1'b1) irq_n++;
   end
   aei_link_model aei_link_model_i (.sys_clk(sys_clk), .go(go), .wr_sel(wr_sel), .addr(addr),
      .wdata(wdata), .req(req), .rdata(rdata), .rdata_valid(rdata_valid), .rd_byte(rd_byte),
      .id_pin_pullup_enable(pull_on));
   aei_core #(.CONV_CYCLES(CONV)) aei_core_i (.sys_clk(sys_clk), .srst(srst), .req(req),
      .rdata(rdata), .rdata_valid(rdata_valid), .vendor_hit(vendor_hit),
      .id_open_raw(id_open_raw), .line_voltage_raw(line_voltage_raw), .code_in(code_in),
      .conv_start(conv_start), .vendor_done_enable(vendor_done_enable), .alt_int(alt_int));
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask
   task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      go = 1'b1;
      wr_sel = w;
      addr = a;
      wdata = d;
      #1 hit = vendor_hit;
      @(negedge sys_clk);
      go = 1'b0;
      if (!w) begin
         check("rdata_valid", 8'h01, {7'h00, rdata_valid});
         @(posedge sys_clk);
         #1 b = rd_byte;
      end
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      check($sformatf("register %h", a), exp, b);
   endtask
   task automatic irq(input int exp_n, input int cyc);
      int start;
      start = irq_n;
      repeat (cyc) @(negedge sys_clk);
      check("alt_int pulses", exp_n[7:0], 8'(irq_n - start));
   endtask
   task automatic start_conv(input logic [2:0] c);
      @(negedge sys_clk);
      code_in = c;
      conv_start = 1'b1;
      @(negedge sys_clk);
      conv_start = 1'b0;
   endtask
   task automatic t_reset;
      logic [5:0] al [6] = '{6'h1D, 6'h1E, 6'h1F, 6'h20, 6'h21, 6'h10};
      foreach (al[i]) rd(al[i], 8'h00);
      check("id pull-up", 8'h01, {7'h00, pull_on});
   endtask
   task automatic t_enable;
      acc(1'b1, 6'h1D, 8'hFF);
      for (int i = 0; i < 3; i++) rd(6'h1D + 6'(i), 8'h27);
      acc(1'b1, 6'h1F, 8'h05);
      rd(6'h1D, 8'h22);
      acc(1'b1, 6'h1E, 8'h01);
      rd(6'h1F, 8'h23);
      acc(1'b1, 6'h20, 8'hFF);
      rd(6'h20, 8'h00);
      acc(1'b1, 6'h21, 8'hFF);
      rd(6'h21, 8'h00);
   endtask
   task automatic t_id;
      acc(1'b1, 6'h1D, 8'h03);
      id_open_raw = 1'b1;
      irq(1, 12);
      rd(6'h20, 8'h01);
      rd(6'h21, 8'h01);
      rd(6'h21, 8'h00);
      acc(1'b1, 6'h1F, 8'h01);
      id_open_raw = 1'b0;
      irq(1, 12);
      rd(6'h21, 8'h01);
      id_open_raw = 1'b1;
      irq(0, 12);
      rd(6'h21, 8'h00);
      acc(1'b1, 6'h1D, 8'h04);
      id_open_raw = 1'b0;
      irq(0, 12);
   endtask
   task automatic t_vdet;
      line_voltage_raw = 1'b1;
      irq(1, 12);
      rd(6'h20, 8'h02);
      rd(6'h21, 8'h02);
      line_voltage_raw = 1'b0;
      irq(1, 12);
      rd(6'h21, 8'h02);
      acc(1'b1, 6'h1D, 8'h00);
      line_voltage_raw = 1'b1;
      irq(0, 12);
      rd(6'h21, 8'h00);
   endtask
   task automatic t_conv;
      vendor_done_enable = 1'b1;
      start_conv(3'h5);
      rd(6'h20, 8'h02);
      check("vendor_hit", 8'h00, {7'h00, hit});
      irq(1, CONV + 12);
      rd(6'h20, 8'h6A);
      rd(6'h20, 8'h6A);
      rd(6'h21, 8'h08);
      acc(1'b0, 6'h36, 8'h00);
      check("vendor_hit", 8'h01, {7'h00, hit});
      rd(6'h20, 8'h2A);
      vendor_done_enable = 1'b0;
      acc(1'b1, 6'h1D, 8'h20);
      start_conv(3'h7);
      irq(1, CONV + 12);
      rd(6'h20, 8'h7A);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      fail_count++;
      give_verdict();
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      srst = 1'b0;
      t_reset();
      t_enable();
      t_id();
      t_vdet();
      t_conv();
      give_verdict();
   end
endmodule
